// ==== rtl/adtk_ctrl.sv ====
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "adtk_defs.svh"
module adtk_ctrl
  import adtk_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [11:0]  paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         adc_done_in,
  input  wire adtk_result_t adc_data_in,
  input  wire logic         touch_done_in,
  input  wire adtk_result_t touch_data_in,
  input  wire logic         stop_halt_mode,
  input  wire logic         bandgap_auto_req,
  input  wire logic [7:0]   ext_pin_req,
  input  wire logic         lvd_req,
  input  wire logic         port1_change_req,
  input  wire logic         timer3_req,
  output logic              irq,
  output logic              conv_touch_irq,
  output logic      [7:0]   ext_pin_irq,
  output logic      [7:0]   ext_pin_wake,
  output logic              lvd_irq,
  output logic              port1_change_irq,
  output logic              timer3_irq,
  output logic              timer3_wake,
  output logic              touch_start,
  output logic              adc_start,
  output logic              touch_power_down,
  output logic              touch_clock_halve,
  output adtk_volt_t        touch_voltage_select,
  output logic      [2:0]   touch_charge_time,
  output logic      [3:0]   conv_channel_select,
  output logic      [1:0]   conv_reference_select,
  output logic              bandgap_on,
  output logic      [2:0]   port0_analog_input_enable
);

  // ****************************************
  // Register state
  // ****************************************
  logic [3:0]  inte_reg;
  logic        touch_done_flag_reg;
  logic [3:0]  chs_reg;
  logic [1:0]  ref_reg;
  logic        bandgap_force_on_reg;
  adtk_event_t stat_reg;
  adtk_event_t stat_en_reg;
  logic        wr_en;
  logic        rd_phase;
  logic        start_ok;
  adtk_byte_t  wbyte;
  adtk_byte_t  rd_next;
  logic        map_next;

  adtk_res_if res ();

  // ****************************************
  // Result store
  // ****************************************
  assign res.adc_done   = adc_done_in;
  assign res.adc_data   = adc_data_in;
  assign res.touch_done = touch_done_in;
  assign res.touch_data = touch_data_in;

  adtk_result_store u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .res     (res.store)
  );

  // ****************************************
  // APB slave
  // ****************************************
  // One wait state so read data come straight from a flop
  assign rd_phase = psel && penable && !pready;
  assign wr_en    = psel && penable && pready && pwrite;
  assign wbyte    = pwdata[7:0];
  // Touch start ignored while powered down or still converting
  assign start_ok = !touch_power_down && touch_done_flag_reg;

  // Read decode; unmapped addresses answer with an error
  always_comb begin
    rd_next  = 8'h00;
    map_next = 1'b1;
    unique case (paddr)
      12'(`ADTK_ADDR(`ADTK_IDX_INTE)):     rd_next = {4'h0, inte_reg};
      12'(`ADTK_ADDR(`ADTK_IDX_SHARED)):   rd_next = res.shared_byte;
      12'(`ADTK_ADDR(`ADTK_IDX_ADC_HIGH)): rd_next = res.adc_high;
      12'(`ADTK_ADDR(`ADTK_IDX_TK_LOW)):   rd_next = res.touch_low;
      12'(`ADTK_ADDR(`ADTK_IDX_TOUCH_CONTROL)):    rd_next = {touch_power_down, touch_done_flag_reg,
                                                      touch_clock_halve, touch_voltage_select,
                                                      touch_charge_time};
      12'(`ADTK_ADDR(`ADTK_IDX_CONVERTER_CHANNEL_SELECT)):    rd_next = {chs_reg, ref_reg, bandgap_force_on_reg,
                                                      1'b0};
      12'(`ADTK_ADDR(`ADTK_IDX_P0AD)):     rd_next = {port0_analog_input_enable, 5'h00};
      12'(`ADTK_ADDR(`ADTK_IDX_STAT)):     rd_next = {6'h00, stat_reg};
      12'(`ADTK_ADDR(`ADTK_IDX_CLR)):      rd_next = 8'h00;
      12'(`ADTK_ADDR(`ADTK_IDX_EN)):       rd_next = {6'h00, stat_en_reg};
      12'(`ADTK_ADDR(`ADTK_IDX_CMD)):      rd_next = 8'h00;
      default:                             map_next = 1'b0;
    endcase
  end

  // Handshake and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (rd_phase) begin
      pready  <= 1'b1;
      pslverr <= !map_next;
      prdata  <= {24'h00_0000, rd_next};
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  // Interrupt enable group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inte_reg <= `ADTK_RST_INTE;
    end else if (wr_en && !pslverr && paddr == 12'(`ADTK_ADDR(`ADTK_IDX_INTE))) begin
      inte_reg <= wbyte[3:0];
    end
  end

  // Touch control fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      touch_power_down     <= `ADTK_RST_PD;
      touch_clock_halve    <= `ADTK_RST_HALVE;
      touch_voltage_select <= adtk_volt_t'(`ADTK_RST_VOLT);
      touch_charge_time    <= `ADTK_RST_TMR;
    end else if (wr_en && !pslverr && paddr == 12'(`ADTK_ADDR(`ADTK_IDX_TOUCH_CONTROL))) begin
      touch_power_down     <= wbyte[`ADTK_TK_PD];
      touch_clock_halve    <= wbyte[`ADTK_TK_HALVE];
      touch_voltage_select <= adtk_volt_t'(wbyte[`ADTK_TK_VOLT]);
      touch_charge_time    <= wbyte[`ADTK_TK_TMR];
    end
  end

  // Converter channel, reference and bandgap force
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chs_reg              <= `ADTK_RST_CHS;
      ref_reg              <= `ADTK_RST_REF;
      bandgap_force_on_reg <= `ADTK_RST_BG;
    end else if (wr_en && !pslverr && paddr == 12'(`ADTK_ADDR(`ADTK_IDX_CONVERTER_CHANNEL_SELECT))) begin
      chs_reg              <= wbyte[`ADTK_CH_SEL];
      ref_reg              <= wbyte[`ADTK_CH_REF];
      bandgap_force_on_reg <= wbyte[`ADTK_CH_BG];
    end
  end

  // Port-0 analog input field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port0_analog_input_enable <= `ADTK_RST_P0;
    end else if (wr_en && !pslverr && paddr == 12'(`ADTK_ADDR(`ADTK_IDX_P0AD))) begin
      port0_analog_input_enable <= wbyte[`ADTK_P0_EN];
    end
  end

  // Status enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_en_reg <= 2'h0;
    end else if (wr_en && !pslverr && paddr == 12'(`ADTK_ADDR(`ADTK_IDX_EN))) begin
      stat_en_reg <= wbyte[1:0];
    end
  end

  // ****************************************
  // Conversion control
  // ****************************************
  // Start commands become one-cycle pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      touch_start <= 1'b0;
      adc_start   <= 1'b0;
    end else begin
      touch_start <= wr_en && !pslverr && paddr == 12'(`ADTK_ADDR(`ADTK_IDX_CMD))
                     && wbyte[`ADTK_EV_TOUCH] && start_ok;
      adc_start   <= wr_en && !pslverr && paddr == 12'(`ADTK_ADDR(`ADTK_IDX_CMD))
                     && wbyte[`ADTK_EV_ADC];
    end
  end

  // Done flag drops at start, rises on finish; finish wins a tie
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      touch_done_flag_reg <= `ADTK_RST_EOC;
    end else if (touch_done_in) begin
      touch_done_flag_reg <= 1'b1;
    end else if (touch_start) begin
      touch_done_flag_reg <= 1'b0;
    end
  end

  // Channel, reference outputs; software keeps reference legal for bandgap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_channel_select   <= `ADTK_RST_CHS;
      conv_reference_select <= `ADTK_RST_REF;
    end else begin
      conv_channel_select   <= chs_reg;
      conv_reference_select <= ref_reg;
    end
  end

  // Bandgap: forced on, but always off in stop or halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bandgap_on <= 1'b0;
    end else begin
      bandgap_on <= !stop_halt_mode && (bandgap_force_on_reg || bandgap_auto_req);
    end
  end

  // ****************************************
  // Interrupt status and gating
  // ****************************************
  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= 2'h0;
    end else begin
      stat_reg <= (stat_reg & ~((wr_en && !pslverr
                   && paddr == 12'(`ADTK_ADDR(`ADTK_IDX_CLR))) ? wbyte[1:0] : 2'h0))
                  | {adc_done_in, touch_done_in};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq            <= 1'b0;
      conv_touch_irq <= 1'b0;
    end else begin
      irq            <= |(stat_reg & stat_en_reg);
      conv_touch_irq <= inte_reg[`ADTK_INTE_CONV] && |stat_reg;
    end
  end

  // Pass-through gates, registered so outputs come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_pin_irq      <= 8'h00;
      ext_pin_wake     <= 8'h00;
      lvd_irq          <= 1'b0;
      port1_change_irq <= 1'b0;
      timer3_irq       <= 1'b0;
      timer3_wake      <= 1'b0;
    end else begin
      ext_pin_irq      <= ext_pin_req & {8{inte_reg[`ADTK_INTE_EXT]}};
      ext_pin_wake     <= ext_pin_req & {8{inte_reg[`ADTK_INTE_EXT]}};
      lvd_irq          <= lvd_req && inte_reg[`ADTK_INTE_EXT];
      port1_change_irq <= port1_change_req && inte_reg[`ADTK_INTE_P1];
      timer3_irq       <= timer3_req && inte_reg[`ADTK_INTE_TM3];
      timer3_wake      <= timer3_req && inte_reg[`ADTK_INTE_TM3];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_conv_irq_gate: assert property (
    ##1 conv_touch_irq == ($past(inte_reg[`ADTK_INTE_CONV]) && |$past(stat_reg)))
    else $error("converter interrupt gate wrong");
  a_ext_lvd_gate: assert property (
    !inte_reg[`ADTK_INTE_EXT] |=> ext_pin_irq == 8'h00 && ext_pin_wake == 8'h00 && !lvd_irq)
    else $error("external pin gate wrong");
  a_port1_gate: assert property (
    port1_change_req && inte_reg[`ADTK_INTE_P1] |=> port1_change_irq)
    else $error("port1 gate wrong");
  a_timer3_pair: assert property (
    (timer3_irq == timer3_wake)
      and (timer3_req && !inte_reg[`ADTK_INTE_TM3] |=> !timer3_irq))
    else $error("timer3 pair wrong");
  a_pd_no_start: assert property (
    touch_power_down |=> !touch_start)
    else $error("start while powered down");
  // Flag drops on an accepted start and rises on the finish pulse
  a_eoc_cycle: assert property (
    touch_start && !touch_done_in |=> !touch_done_flag_reg)
    else $error("done flag not cleared at start");
  a_eoc_set_wins: assert property (
    touch_done_in |=> touch_done_flag_reg)
    else $error("done flag not set on finish");
  a_busy_no_start: assert property (
    !touch_done_flag_reg |=> !touch_start)
    else $error("start while converting");
  a_halve_write: assert property (
    wr_en && paddr == 12'(`ADTK_ADDR(`ADTK_IDX_TOUCH_CONTROL)) |=>
      touch_clock_halve == $past(wbyte[`ADTK_TK_HALVE]))
    else $error("clock halve not stored");
  a_volt_time: assert property (
    $changed(touch_voltage_select) || $changed(touch_charge_time) |->
      $past(wr_en) && $past(paddr) == 12'(`ADTK_ADDR(`ADTK_IDX_TOUCH_CONTROL)))
    else $error("touch fields changed without write");
  a_time_write: assert property (
    wr_en && paddr == 12'(`ADTK_ADDR(`ADTK_IDX_TOUCH_CONTROL)) |=>
      touch_charge_time == $past(wbyte[`ADTK_TK_TMR]))
    else $error("charge time not stored");
  a_bandgap_off: assert property (
    stop_halt_mode |=> !bandgap_on)
    else $error("bandgap on in stop or halt");
  a_bandgap_force: assert property (
    bandgap_force_on_reg && !stop_halt_mode |=> bandgap_on)
    else $error("forced bandgap off");
  a_p0_hold: assert property (
    $changed(port0_analog_input_enable) |-> $past(wr_en)
      && $past(paddr) == 12'(`ADTK_ADDR(`ADTK_IDX_P0AD)))
    else $error("analog enable changed without write");

  c_touch_run: cover property (touch_start ##[1:50] touch_done_in);
  c_irq_raise: cover property (!irq ##1 irq);
  c_bus_error: cover property (pready && pslverr);
  c_timer3_pass: cover property (timer3_req && inte_reg[`ADTK_INTE_TM3] ##1 timer3_irq);
endmodule

// ==== rtl/adtk_defs.svh ====
`ifndef ADTK_DEFS_SVH
`define ADTK_DEFS_SVH

// ****************************************
// Register indices and byte addresses
// ****************************************
`define ADTK_IDX_INTE      8'ha9
`define ADTK_IDX_SHARED    8'haa
`define ADTK_IDX_ADC_HIGH  8'hab
`define ADTK_IDX_TK_LOW    8'hac
`define ADTK_IDX_TOUCH_CONTROL     8'had
`define ADTK_IDX_CONVERTER_CHANNEL_SELECT     8'hae
`define ADTK_IDX_P0AD      8'haf
`define ADTK_IDX_STAT      8'hb0
`define ADTK_IDX_CLR       8'hb1
`define ADTK_IDX_EN        8'hb2
`define ADTK_IDX_CMD       8'hb3
`define ADTK_ADDR(idx)     {2'h0, idx, 2'h0}

// ****************************************
// Field positions
// ****************************************
`define ADTK_INTE_CONV     3
`define ADTK_INTE_EXT      2
`define ADTK_INTE_P1       1
`define ADTK_INTE_TM3      0
`define ADTK_TK_PD         7
`define ADTK_TK_EOC        6
`define ADTK_TK_HALVE      5
`define ADTK_TK_VOLT       4:3
`define ADTK_TK_TMR        2:0
`define ADTK_CH_SEL        7:4
`define ADTK_CH_REF        3:2
`define ADTK_CH_BG         1
`define ADTK_P0_EN         7:5
`define ADTK_EV_TOUCH      0
`define ADTK_EV_ADC        1

// ****************************************
// Reset values
// ****************************************
`define ADTK_RST_INTE      4'h0
`define ADTK_RST_PD        1'b1
`define ADTK_RST_EOC       1'b1
`define ADTK_RST_HALVE     1'b0
`define ADTK_RST_VOLT      2'h0
`define ADTK_RST_TMR       3'h4
`define ADTK_RST_CHS       4'hf
`define ADTK_RST_REF       2'h0
`define ADTK_RST_BG        1'b0
`define ADTK_RST_P0        3'h0

`endif

// ==== rtl/adtk_pkg.sv ====
package adtk_pkg;
  typedef logic [7:0]  adtk_byte_t;
  typedef logic [11:0] adtk_result_t;
  typedef logic [1:0]  adtk_event_t;
  // Touch operating voltage, in encoding order
  typedef enum logic [1:0] {
    ADTK_V_SUPPLY,
    ADTK_V_2P8,
    ADTK_V_4P0,
    ADTK_V_3P2
  } adtk_volt_t;
endpackage

// ==== rtl/adtk_res_if.sv ====
`timescale 1ns/1ps
// Result capture path between the control logic and the result store
interface adtk_res_if;
  import adtk_pkg::*;
  logic         adc_done;
  adtk_result_t adc_data;
  logic         touch_done;
  adtk_result_t touch_data;
  adtk_byte_t   shared_byte;
  adtk_byte_t   adc_high;
  adtk_byte_t   touch_low;
  modport store (input adc_done, adc_data, touch_done, touch_data,
                 output shared_byte, adc_high, touch_low);
  modport ctrl  (output adc_done, adc_data, touch_done, touch_data,
                 input shared_byte, adc_high, touch_low);
endinterface

// ==== rtl/adtk_result_store.sv ====
`timescale 1ns/1ps
`include "adtk_defs.svh"
module adtk_result_store
  import adtk_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  adtk_res_if.store res
);

  // ****************************************
  // Result capture
  // ****************************************
  // Results are held until the next conversion, so reads never tear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res.adc_high <= 8'h00;
    end else if (res.adc_done) begin
      res.adc_high <= res.adc_data[11:4];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res.touch_low <= 8'h00;
    end else if (res.touch_done) begin
      res.touch_low <= res.touch_data[7:0];
    end
  end

  // Shared byte: converter low nibble above, touch high nibble below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res.shared_byte <= 8'h00;
    end else begin
      if (res.adc_done) begin
        res.shared_byte[7:4] <= res.adc_data[3:0];
      end
      if (res.touch_done) begin
        res.shared_byte[3:0] <= res.touch_data[11:8];
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_touch_split: assert property (@(posedge pclk) disable iff (!presetn)
    res.touch_done |=> res.shared_byte[3:0] == $past(res.touch_data[11:8])
                      && res.touch_low == $past(res.touch_data[7:0]))
    else $error("touch result split wrong");
  a_adc_split: assert property (@(posedge pclk) disable iff (!presetn)
    res.adc_done |=> res.adc_high == $past(res.adc_data[11:4])
                    && res.shared_byte[7:4] == $past(res.adc_data[3:0]))
    else $error("converter result split wrong");
endmodule

// ==== verif/adtk_sense_model.sv ====
`timescale 1ns/1ps
// ****************************************
// Sensing pins: electrodes and analog inputs
// ****************************************
module adtk_sense_model
  import adtk_pkg::*;
#(
  parameter int           DELAY     = 20,
  parameter adtk_result_t TOUCH_VAL = 12'habc,
  parameter adtk_result_t ADC_VAL   = 12'h5a3
)(
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   touch_start,
  input  wire logic   adc_start,
  output logic        touch_done_in,
  output adtk_result_t touch_data_in,
  output logic        adc_done_in,
  output adtk_result_t adc_data_in
);
  int t_cnt;
  int a_cnt;

  // Charge and settle time, then one done pulse; data is junk outside it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_cnt         <= 0;
      a_cnt         <= 0;
      touch_done_in <= 1'b0;
      adc_done_in   <= 1'b0;
      touch_data_in <= 12'h000;
      adc_data_in   <= 12'h000;
    end else begin
      touch_done_in <= (t_cnt == 1);
      adc_done_in   <= (a_cnt == 1);
      touch_data_in <= (t_cnt == 1) ? TOUCH_VAL : ~touch_data_in;
      adc_data_in   <= (a_cnt == 1) ? ADC_VAL : ~adc_data_in;
      t_cnt         <= touch_start ? DELAY : ((t_cnt != 0) ? t_cnt - 1 : 0);
      a_cnt         <= adc_start ? DELAY : ((a_cnt != 0) ? a_cnt - 1 : 0);
    end
  end
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`include "adtk_defs.svh"
module testbench;
  import adtk_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, adc_done_in, touch_done_in, stop_halt_mode = 0;
  logic bandgap_auto_req = 0, lvd_req = 0, port1_change_req = 0, timer3_req = 0;
  logic [7:0] ext_pin_req = 0, ext_pin_irq, ext_pin_wake, r;
  adtk_result_t adc_data_in, touch_data_in;
  logic irq, cti, lvd_irq, p1_irq, t3_irq, t3_wake, t_start, a_start, pd, halve, bg, e;
  adtk_volt_t volt;
  logic [2:0] ctime, p0;
  logic [3:0] chan;
  logic [1:0] vref;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  localparam logic [11:0] A_INTE = `ADTK_ADDR(`ADTK_IDX_INTE);
  localparam logic [11:0] A_SHR  = `ADTK_ADDR(`ADTK_IDX_SHARED);
  localparam logic [11:0] A_ADH  = `ADTK_ADDR(`ADTK_IDX_ADC_HIGH);
  localparam logic [11:0] A_TKL  = `ADTK_ADDR(`ADTK_IDX_TK_LOW);
  localparam logic [11:0] A_TKC  = `ADTK_ADDR(`ADTK_IDX_TOUCH_CONTROL);
  localparam logic [11:0] A_CHS  = `ADTK_ADDR(`ADTK_IDX_CONVERTER_CHANNEL_SELECT);
  localparam logic [11:0] A_P0   = `ADTK_ADDR(`ADTK_IDX_P0AD);
  localparam logic [11:0] A_STAT = `ADTK_ADDR(`ADTK_IDX_STAT);
  localparam logic [11:0] A_CLR  = `ADTK_ADDR(`ADTK_IDX_CLR);
  localparam logic [11:0] A_EN   = `ADTK_ADDR(`ADTK_IDX_EN);
  localparam logic [11:0] A_CMD  = `ADTK_ADDR(`ADTK_IDX_CMD);

  always #20 pclk = ~pclk;

  adtk_ctrl u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_done_in(adc_done_in), .adc_data_in(adc_data_in),
    .touch_done_in(touch_done_in), .touch_data_in(touch_data_in),
    .stop_halt_mode(stop_halt_mode), .bandgap_auto_req(bandgap_auto_req),
    .ext_pin_req(ext_pin_req), .lvd_req(lvd_req), .port1_change_req(port1_change_req),
    .timer3_req(timer3_req), .irq(irq), .conv_touch_irq(cti), .ext_pin_irq(ext_pin_irq),
    .ext_pin_wake(ext_pin_wake), .lvd_irq(lvd_irq), .port1_change_irq(p1_irq),
    .timer3_irq(t3_irq), .timer3_wake(t3_wake), .touch_start(t_start), .adc_start(a_start),
    .touch_power_down(pd), .touch_clock_halve(halve), .touch_voltage_select(volt),
    .touch_charge_time(ctime), .conv_channel_select(chan), .conv_reference_select(vref),
    .bandgap_on(bg), .port0_analog_input_enable(p0));

  adtk_sense_model u_sense (.pclk(pclk), .presetn(presetn), .touch_start(t_start),
    .adc_start(a_start), .touch_done_in(touch_done_in), .touch_data_in(touch_data_in),
    .adc_done_in(adc_done_in), .adc_data_in(adc_data_in));

  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Slave answers when it likes; only the cycle ceiling ends a stall
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check(input logic [11:0] g, input logic [11:0] x);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    xfer(1'b0, a, 8'h00);
    check({4'h0, r}, {4'h0, x});
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic conclude;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the sequence needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("Error at %0t: cycle limit reached", $time);
      conclude;
    end
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_INTE, 8'h00);
    rd(A_TKC, 8'hc4);
    rd(A_CHS, 8'hf0);
    check(12'(pd), 12'h1);
    // Touch conversion: flag low while running, count split across two bytes
    wr(A_TKC, 8'h00);
    wr(A_CMD, 8'h01);
    rd(A_TKC, 8'h00);
    settle(30);
    rd(A_TKC, 8'h40);
    wr(A_CMD, 8'h02);
    settle(30);
    rd(A_TKL, 8'hbc);
    rd(A_SHR, 8'h3a);
    rd(A_ADH, 8'h5a);
    // Sticky status, enables, clear
    rd(A_STAT, 8'h03);
    check(12'(cti), 12'h0);
    wr(A_INTE, 8'h08);
    wr(A_EN, 8'h01);
    settle(2);
    check({10'h0, irq, cti}, 12'h3);
    wr(A_CLR, 8'h03);
    settle(2);
    check({10'h0, irq, cti}, 12'h0);
    rd(A_CLR, 8'h00);
    // Start refused while powered down
    wr(A_TKC, 8'h80);
    wr(A_CMD, 8'h01);
    settle(30);
    rd(A_STAT, 8'h00);
    rd(A_TKC, 8'hc0);
    // Each enable bit gates only its own group
    ext_pin_req <= 8'ha5;
    lvd_req <= 1'b1;
    port1_change_req <= 1'b1;
    timer3_req <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(A_INTE, 8'(1 << i));
      settle(2);
      rd(A_INTE, 8'(1 << i));
      check({ext_pin_irq, ext_pin_wake[3:0]}, (i == 2) ? 12'ha55 : 12'h000);
      check({9'h0, lvd_irq, p1_irq, t3_irq}, {9'h0, i == 2, i == 1, i == 0});
      check(12'(t3_wake), 12'(i == 0));
      check({4'h0, ext_pin_wake}, (i == 2) ? 12'h0a5 : 12'h000);
    end
    // Touch field encodings, done flag not writable
    for (int i = 0; i < 4; i++) begin
      wr(A_TKC, {2'b10, i[0], i[1:0], 3'(7 - i)});
      settle(1);
      rd(A_TKC, {2'b11, i[0], i[1:0], 3'(7 - i)});
      check({6'h0, halve, volt, ctime}, {6'h0, i[0], i[1:0], 3'(7 - i)});
    end
    // Channel, reference and forced bandgap against stop/halt
    wr(A_CHS, 8'h27);
    settle(2);
    rd(A_CHS, 8'h26);
    check({6'h0, chan, vref}, 12'h009);
    check(12'(bg), 12'h1);
    stop_halt_mode <= 1'b1;
    settle(2);
    check(12'(bg), 12'h0);
    // Leave stop/halt on the clock edge that ends the write
    wr(A_CHS, 8'h20);
    stop_halt_mode <= 1'b0;
    bandgap_auto_req <= 1'b1;
    settle(2);
    check(12'(bg), 12'h1);
    bandgap_auto_req <= 1'b0;
    settle(2);
    check(12'(bg), 12'h0);
    // Port-0 analog pins, every combination
    for (int i = 0; i < 8; i++) begin
      wr(A_P0, {3'(i), 5'h00});
      settle(1);
      rd(A_P0, {3'(i), 5'h00});
      check(12'(p0), 12'(i));
    end
    // Unmapped place refused
    xfer(1'b1, `ADTK_ADDR(8'hb4), 8'hff);
    check(12'(e), 12'h1);
    rd(`ADTK_ADDR(8'hb4), 8'h00);
    conclude;
  end
endmodule
